// [src/rme_exec.sv]
// Execution unit for immediate loads, bank transfer, convert, multiply, negate, normalise
//
// Summary of operation
// - Long immediate takes two following words, low then high, writes cycle 3, flags kept.
// - Short immediate writes the 5-bit field zero-extended in cycle 2, flags kept.
// - Bank copy reads active bank in cycle 1, writes other bank cycle 2.
// - Mantissa convert builds a sign-extended signed integer from float mantissa and sign.
// - Convert sets Z on zero result, N and C on negative result.
// - Multiply writes the unsigned 32-bit product of both low halves to destination.
// - Multiply sets Z on zero, N from product bit 31, C on nonzero.
// - Negate writes zero minus destination back to destination.
// - Negating the most negative value wraps; software must not rely on it.
// - Negate sets Z on zero, N on negative, C from the borrow.
// - Convert, multiply and negate read operands in cycle 1, write in cycle 3.
// - Normalise writes the signed right-shift count that normalises the unsigned source.
// - Normalise sets Z on zero, N on negative, C when source below 10 hex.
// - That count is also the exponent correction for the normalising shift.
`timescale 1ns/100ps
`default_nettype none
module rme_exec (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  // Instruction issue
  input  wire logic                i_issue,
  input  wire rme_pkg::rme_insn_s  i_insn,
  input  wire logic                i_bank,
  output logic                     o_busy,
  // Instruction stream words for the long immediate
  input  wire logic [15:0]         i_ext_word,
  output logic                     o_ext_take,
  // Register file read port
  output rme_pkg::rme_rd_s         o_rd,
  input  wire logic [31:0]         i_src_data,
  input  wire logic [31:0]         i_dst_data,
  // Register file write port
  output rme_pkg::rme_wr_s         o_wr,
  // Flags
  output logic                     o_flag_upd,
  output rme_pkg::rme_flags_s      o_flags
);

  // ****************************************
  // Declarations
  // ****************************************
  rme_pkg::rme_state_e  state_reg;
  rme_pkg::rme_state_e  state_next;
  logic [5:0]           op_reg;
  logic [4:0]           src_reg;
  logic [4:0]           dst_reg;
  logic                 bank_reg;
  logic [31:0]          opnd_s_reg;
  logic [31:0]          opnd_d_reg;
  logic [15:0]          imm_lo_reg;
  logic                 accept;
  logic [31:0]          norm_cnt;
  logic [31:0]          alu_res;
  rme_pkg::rme_flags_s  alu_flags;

  // A new instruction is only taken while idle; unknown opcodes pass by
  assign accept = (state_reg == rme_pkg::ST_IDLE) && i_issue
                  && rme_pkg::is_known(i_insn.opcode);

  // ****************************************
  // Arithmetic
  // ****************************************
  rme_norm u_norm (
    .i_src   (opnd_s_reg),
    .o_count (norm_cnt)
  );

  rme_alu u_alu (
    .i_op    (op_reg),
    .i_src   (opnd_s_reg),
    .i_dst   (opnd_d_reg),
    .i_norm  (norm_cnt),
    .o_res   (alu_res),
    .o_flags (alu_flags)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Cycle 1 is READ, cycle 2 EXEC, cycle 3 WBACK
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rme_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = rme_pkg::ST_READ;
        end
      end
      rme_pkg::ST_READ: begin
        state_next = rme_pkg::ST_EXEC;
      end
      rme_pkg::ST_EXEC: begin
        // Short moves are complete after their cycle-2 write
        if ((op_reg == rme_pkg::OP_LOAD_SHORT) || (op_reg == rme_pkg::OP_COPY_OTHER)) begin
          state_next = rme_pkg::ST_IDLE;
        end else begin
          state_next = rme_pkg::ST_WBACK;
        end
      end
      rme_pkg::ST_WBACK: begin
        state_next = rme_pkg::ST_IDLE;
      end
      default: begin
        state_next = rme_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= rme_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Busy is registered so the decoder sees no combinational path
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_next != rme_pkg::ST_IDLE);
    end
  end

  // Instruction fields held for the life of the operation
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      op_reg   <= 6'h00;
      src_reg  <= 5'h00;
      dst_reg  <= 5'h00;
      bank_reg <= 1'b0;
    end else if (accept) begin
      op_reg   <= i_insn.opcode;
      src_reg  <= i_insn.src;
      dst_reg  <= i_insn.dst;
      bank_reg <= i_bank;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read strobe stands in cycle 1 only, in the active bank
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd <= '{en: 1'b0, bank: 1'b0, src_addr: 5'h00, dst_addr: 5'h00};
    end else begin
      o_rd.en <= accept && rme_pkg::reads_regs(i_insn.opcode);
      if (accept) begin
        o_rd.bank     <= i_bank;
        o_rd.src_addr <= i_insn.src;
        o_rd.dst_addr <= i_insn.dst;
      end
    end
  end

  // Operands caught at the end of cycle 1 and held until the next read
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      opnd_s_reg <= rme_pkg::WORD_RST;
      opnd_d_reg <= rme_pkg::WORD_RST;
    end else if (o_rd.en) begin
      opnd_s_reg <= i_src_data;
      opnd_d_reg <= i_dst_data;
    end
  end

  // ****************************************
  // Instruction-stream data words
  // ****************************************
  // Take strobe in cycles 1 and 2; fetch steps past each word taken
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_take <= 1'b0;
    end else begin
      o_ext_take <= (accept && (i_insn.opcode == rme_pkg::OP_LOAD_LONG))
                    || ((state_reg == rme_pkg::ST_READ)
                        && (op_reg == rme_pkg::OP_LOAD_LONG));
    end
  end

  // First word is the low half
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      imm_lo_reg <= rme_pkg::HALF_RST;
    end else if (o_ext_take && (state_reg == rme_pkg::ST_READ)) begin
      imm_lo_reg <= i_ext_word;
    end
  end

  // ****************************************
  // Register write-back
  // ****************************************
  // Short moves write in cycle 2, the rest in cycle 3
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wr <= '{en: 1'b0, bank: 1'b0, addr: 5'h00, data: rme_pkg::WORD_RST};
    end else begin
      o_wr.en <= 1'b0;
      if ((state_reg == rme_pkg::ST_READ) && (op_reg == rme_pkg::OP_LOAD_SHORT)) begin
        o_wr <= '{en: 1'b1, bank: bank_reg, addr: dst_reg,
                  data: {27'h0, src_reg}};
      end else if ((state_reg == rme_pkg::ST_READ)
                   && (op_reg == rme_pkg::OP_COPY_OTHER)) begin
        o_wr <= '{en: 1'b1, bank: ~bank_reg, addr: dst_reg,
                  data: i_src_data};
      end else if ((state_reg == rme_pkg::ST_EXEC)
                   && (op_reg == rme_pkg::OP_LOAD_LONG)) begin
        o_wr <= '{en: 1'b1, bank: bank_reg, addr: dst_reg,
                  data: {i_ext_word, imm_lo_reg}};
      end else if ((state_reg == rme_pkg::ST_EXEC) && rme_pkg::is_alu(op_reg)) begin
        o_wr <= '{en: 1'b1, bank: bank_reg, addr: dst_reg,
                  data: alu_res};
      end
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  // Only arithmetic results touch the flags; moves leave them alone
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flag_upd <= 1'b0;
      o_flags    <= '{z: 1'b0, n: 1'b0, c: 1'b0};
    end else begin
      o_flag_upd <= (state_reg == rme_pkg::ST_EXEC) && rme_pkg::is_alu(op_reg);
      if ((state_reg == rme_pkg::ST_EXEC) && rme_pkg::is_alu(op_reg)) begin
        o_flags <= alu_flags;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_long_wr;
    accept && (i_insn.opcode == rme_pkg::OP_LOAD_LONG)
      |-> ##1 o_ext_take ##1 o_ext_take && !o_wr.en
          ##1 o_wr.en && !o_flag_upd && (o_wr.data[15:0] == $past(i_ext_word, 2));
  endproperty
  a_long_wr: assert property (p_long_wr)
    else $error("long immediate write wrong");

  property p_long_take;
    accept && (i_insn.opcode == rme_pkg::OP_LOAD_LONG)
      |-> ##1 o_ext_take [*2] ##1 !o_ext_take;
  endproperty
  a_long_take: assert property (p_long_take)
    else $error("long immediate word take count wrong");

  property p_short_wr;
    accept && (i_insn.opcode == rme_pkg::OP_LOAD_SHORT)
      |-> ##2 o_wr.en && !o_flag_upd && (o_wr.data == {27'h0, $past(i_insn.src, 2)});
  endproperty
  a_short_wr: assert property (p_short_wr)
    else $error("short immediate write wrong");

  property p_bank_copy;
    accept && (i_insn.opcode == rme_pkg::OP_COPY_OTHER)
      |-> ##1 o_rd.en ##1 o_wr.en && (o_wr.bank != $past(i_bank, 2));
  endproperty
  a_bank_copy: assert property (p_bank_copy)
    else $error("bank copy timing or bank wrong");

  property p_alu_timing;
    accept && rme_pkg::is_alu(i_insn.opcode)
      |-> ##1 o_rd.en ##1 !o_wr.en ##1 o_wr.en && o_flag_upd;
  endproperty
  a_alu_timing: assert property (p_alu_timing)
    else $error("arithmetic read or write cycle wrong");

  property p_conv_flags;
    o_flag_upd && (op_reg == rme_pkg::OP_MANT_TO_INT)
      |-> (o_flags.c == o_wr.data[31]) && (o_flags.n == o_wr.data[31])
          && (o_wr.data[31] == opnd_s_reg[31]);
  endproperty
  a_conv_flags: assert property (p_conv_flags)
    else $error("convert flags wrong");

  property p_half_prod;
    o_flag_upd && (op_reg == rme_pkg::OP_HALF_MULTIPLY)
      |-> (o_wr.data == opnd_s_reg[15:0] * opnd_d_reg[15:0])
          && (o_flags.c == (o_wr.data != 32'h0000_0000)) && (o_flags.n == o_wr.data[31]);
  endproperty
  a_half_prod: assert property (p_half_prod)
    else $error("multiply product or flags wrong");

  property p_negate;
    o_flag_upd && (op_reg == rme_pkg::OP_TWOS_NEGATE)
      |-> (o_wr.data + opnd_d_reg == 32'h0000_0000)
          && (o_flags.c == (opnd_d_reg != 32'h0000_0000));
  endproperty
  a_negate: assert property (p_negate)
    else $error("negate result or borrow wrong");

  property p_norm_flags;
    o_flag_upd && (op_reg == rme_pkg::OP_NORM_COUNT)
      |-> (o_flags.c == (opnd_s_reg < 32'h0000_0010)) && (o_flags.n == o_wr.data[31]);
  endproperty
  a_norm_flags: assert property (p_norm_flags)
    else $error("normalise flags wrong");

endmodule // rme_exec
`default_nettype wire

// [src/rme_pkg.sv]
// Shared opcodes, carriers, states and decode helpers for the move/multiply execution unit
package rme_pkg;

  // ****************************************
  // Opcodes handled by this unit
  // ****************************************
  localparam logic [5:0] OP_TWOS_NEGATE   = 6'h08;
  localparam logic [5:0] OP_HALF_MULTIPLY = 6'h10;
  localparam logic [5:0] OP_LOAD_SHORT    = 6'h23;
  localparam logic [5:0] OP_COPY_OTHER    = 6'h24;
  localparam logic [5:0] OP_LOAD_LONG     = 6'h26;
  localparam logic [5:0] OP_MANT_TO_INT   = 6'h37;
  localparam logic [5:0] OP_NORM_COUNT    = 6'h38;

  // ****************************************
  // Field positions, limits and reset values
  // ****************************************
  localparam logic [5:0]  NORM_MSB      = 6'h17;          // Hidden-bit position
  localparam logic [31:0] NORM_C_LIMIT  = 32'h0000_0010;  // Carry when source is below this
  localparam logic [31:0] WORD_RST      = 32'h0000_0000;
  localparam logic [15:0] HALF_RST      = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [5:0] opcode;
    logic [4:0] src;     // Source register or 5-bit immediate
    logic [4:0] dst;
  } rme_insn_s;

  typedef struct packed {
    logic       en;
    logic       bank;
    logic [4:0] src_addr;
    logic [4:0] dst_addr;
  } rme_rd_s;

  typedef struct packed {
    logic        en;
    logic        bank;
    logic [4:0]  addr;
    logic [31:0] data;
  } rme_wr_s;

  typedef struct packed {
    logic z;
    logic n;
    logic c;
  } rme_flags_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_EXEC  = 2'b11,
    ST_WBACK = 2'b10
  } rme_state_e;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_alu(input logic [5:0] op);
    return (op == OP_TWOS_NEGATE) || (op == OP_HALF_MULTIPLY) || (op == OP_MANT_TO_INT)
           || (op == OP_NORM_COUNT);
  endfunction

  function automatic logic is_known(input logic [5:0] op);
    return is_alu(op) || (op == OP_LOAD_SHORT) || (op == OP_COPY_OTHER)
           || (op == OP_LOAD_LONG);
  endfunction

  function automatic logic reads_regs(input logic [5:0] op);
    return is_alu(op) || (op == OP_COPY_OTHER);
  endfunction

endpackage

// [src/rme_norm.sv]
// Normalisation shift count for an unsigned source word
`timescale 1ns/100ps
`default_nettype none
module rme_norm (
  // Operand
  input  wire logic [31:0] i_src,
  // Signed right-shift count
  output logic      [31:0] o_count
);

  logic [5:0] msb;

  // ****************************************
  // Leading-one search and offset to hidden bit
  // ****************************************
  // Highest set bit wins; a zero source reports a zero count
  always_comb begin
    msb = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (i_src[i]) begin
        msb = 6'(i);
      end
    end
  end

  // Count is also the exponent correction after the shift
  assign o_count = (i_src == rme_pkg::WORD_RST) ? rme_pkg::WORD_RST
                 : {26'h0, msb} - {26'h0, rme_pkg::NORM_MSB};

endmodule // rme_norm
`default_nettype wire

// [src/rme_alu.sv]
// Result and flag logic for convert, multiply, negate and normalise operations
`timescale 1ns/100ps
`default_nettype none
module rme_alu (
  // Operation and operands
  input  wire logic [5:0]        i_op,
  input  wire logic [31:0]       i_src,
  input  wire logic [31:0]       i_dst,
  input  wire logic [31:0]       i_norm,
  // Result
  output logic      [31:0]       o_res,
  output rme_pkg::rme_flags_s    o_flags
);

  logic [32:0] diff;
  logic [31:0] mag;

  // Zero and negative from the result, carry as supplied
  function automatic rme_pkg::rme_flags_s flags_of(input logic [31:0] r, input logic c);
    return '{z: (r == rme_pkg::WORD_RST), n: r[31], c: c};
  endfunction

  // ****************************************
  // Datapath
  // ****************************************
  // Subtract from zero as 33 bits so the top bit is the borrow
  assign diff = {1'b0, rme_pkg::WORD_RST} - {1'b0, i_dst};
  // Mantissa with hidden bit restored
  assign mag  = {8'h00, 1'b1, i_src[22:0]};

  always_comb begin
    o_res   = i_dst;
    o_flags = '{z: 1'b0, n: 1'b0, c: 1'b0};
    case (i_op)
      rme_pkg::OP_MANT_TO_INT: begin
        o_res   = i_src[31] ? (rme_pkg::WORD_RST - mag) : mag;
        o_flags = flags_of(o_res, o_res[31]);
      end
      rme_pkg::OP_HALF_MULTIPLY: begin
        o_res   = {16'h0, i_dst[15:0]} * {16'h0, i_src[15:0]};
        o_flags = flags_of(o_res, o_res != rme_pkg::WORD_RST);
      end
      rme_pkg::OP_TWOS_NEGATE: begin
        // Most negative value wraps onto itself
        o_res   = diff[31:0];
        o_flags = flags_of(diff[31:0], diff[32]);
      end
      rme_pkg::OP_NORM_COUNT: begin
        o_res   = i_norm;
        o_flags = flags_of(i_norm, i_src < rme_pkg::NORM_C_LIMIT);
      end
      default: begin
        o_res   = i_dst;
        o_flags = '{z: 1'b0, n: 1'b0, c: 1'b0};
      end
    endcase
  end

endmodule // rme_alu
`default_nettype wire

// [tb/rme_rf_model.sv]
// Dual-bank register file model facing the execution unit
`timescale 1ns/100ps
`default_nettype none
module rme_rf_model (
  // Clock
  input  wire logic             i_clk,
  // Ports from the unit
  input  wire rme_pkg::rme_rd_s i_rd,
  input  wire rme_pkg::rme_wr_s i_wr,
  // Read data
  output logic      [31:0]      o_src_data,
  output logic      [31:0]      o_dst_data
);
  logic [31:0] mem [2][32];
  logic [31:0] last_src = 32'h0000_0000;
  logic [31:0] last_dst = 32'h0000_0000;

  // Same-cycle read; outside a read the lines toggle so stale data never matches
  always_comb begin
    o_src_data = i_rd.en ? mem[i_rd.bank][i_rd.src_addr] : ~last_src;
    o_dst_data = i_rd.en ? mem[i_rd.bank][i_rd.dst_addr] : ~last_dst;
  end

  // Remember what was shown, and take writes; the bench also preloads mem directly
  always @(posedge i_clk) begin
    last_src <= o_src_data;
    last_dst <= o_dst_data;
    if (i_wr.en) mem[i_wr.bank][i_wr.addr] <= i_wr.data;
  end
endmodule // rme_rf_model
`default_nettype wire

// [tb/rme_exec_tb.sv]
// Self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module rme_exec_tb;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_issue = 1'b0, i_bank = 1'b0;
  rme_pkg::rme_insn_s i_insn = '0;
  logic [15:0] i_ext_word;
  logic o_busy, o_ext_take, o_flag_upd;
  rme_pkg::rme_rd_s o_rd;
  rme_pkg::rme_wr_s o_wr;
  rme_pkg::rme_flags_s o_flags, flags_exp;
  logic [31:0] i_src_data, i_dst_data;
  logic [15:0] ext_lo = 16'h0000, ext_hi = 16'h0000;
  int ext_idx = 0, err_total = 0, total_checks = 0, cyc = 0, seed, k;
  logic [5:0] ops [7] = '{6'h08, 6'h10, 6'h23, 6'h24, 6'h26, 6'h37, 6'h38};
  localparam int CYC_MAX = 5000;

  rme_exec rme_exec_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_issue(i_issue), .i_insn(i_insn),
    .i_bank(i_bank), .o_busy(o_busy), .i_ext_word(i_ext_word), .o_ext_take(o_ext_take),
    .o_rd(o_rd), .i_src_data(i_src_data), .i_dst_data(i_dst_data), .o_wr(o_wr),
    .o_flag_upd(o_flag_upd), .o_flags(o_flags));
  rme_rf_model rme_rf_model_i (.i_clk(i_clk), .i_rd(o_rd), .i_wr(o_wr),
    .o_src_data(i_src_data), .o_dst_data(i_dst_data));

  // Clock and hang guard
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      err_total++;
      stop_test();
    end
  end

  // Instruction stream: low word, high word, then the inverted high word once consumed
  assign i_ext_word = (ext_idx == 0) ? ext_lo : (ext_idx == 1) ? ext_hi : ~ext_hi;
  always @(posedge i_clk) if (o_ext_take) ext_idx <= ext_idx + 1;

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected bit at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected word at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flags(input rme_pkg::rme_flags_s got, input rme_pkg::rme_flags_s exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected flags at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Expected result of each operation
  function automatic logic [31:0] f_res(input logic [5:0] op, input logic [31:0] s, d,
                                        input logic [4:0] imm, input logic [15:0] lo, hi);
    logic [31:0] m;
    m = {8'h00, 1'b1, s[22:0]};
    case (op)
      6'h26: return {hi, lo};
      6'h23: return {27'h0, imm};
      6'h24: return s;
      6'h37: return s[31] ? 32'h0000_0000 - m : m;
      6'h10: return d[15:0] * s[15:0];
      6'h08: return 32'h0000_0000 - d;
      default: begin
        m = 32'h0000_0000;
        for (int i = 0; i < 32; i++) if (s[i]) m = 32'(i - 23);
        return m;
      end
    endcase
  endfunction
  function automatic rme_pkg::rme_flags_s f_flags(input logic [5:0] op,
                                                  input logic [31:0] r, s, d);
    rme_pkg::rme_flags_s f;
    f.z = (r == 32'h0000_0000);
    f.n = r[31];
    f.c = (op == 6'h37) ? r[31] : (op == 6'h10) ? (r != 32'h0000_0000) :
          (op == 6'h08) ? (d != 32'h0000_0000) : (s < 32'h0000_0010);
    return f;
  endfunction

  // One issue; hold above 1 keeps the request up while busy, which must be refused
  task automatic run(input logic [5:0] op, input logic [4:0] src, dst, input logic bank,
                     input logic [31:0] sv, dv, input int hold);
    logic [31:0] s, d, ed;
    int lat, takes;
    logic ar, rd;
    ar = op inside {6'h08, 6'h10, 6'h37, 6'h38};
    rd = ar || (op == 6'h24);
    lat = (op inside {6'h23, 6'h24}) ? 2 : (ar || op == 6'h26) ? 3 : 0;
    takes = 0;
    @(negedge i_clk);
    rme_rf_model_i.mem[bank][src] = sv;
    rme_rf_model_i.mem[bank][dst] = dv;
    s = rme_rf_model_i.mem[bank][src];
    d = rme_rf_model_i.mem[bank][dst];
    ext_lo = sv[15:0];
    ext_hi = dv[31:16];
    ext_idx = 0;
    ed = f_res(op, s, d, src, ext_lo, ext_hi);
    if (ar) flags_exp = f_flags(op, ed, s, d);
    i_insn = {op, src, dst};
    i_bank = bank;
    i_issue = 1'b1;
    for (int n = 1; n <= 4; n++) begin
      @(negedge i_clk);
      if (n == hold) i_issue = 1'b0;
      if (o_ext_take === 1'b1) takes++;
      chk_bit(o_busy, n <= lat);
      chk_bit(o_rd.en, rd && n == 1);
      chk_bit(o_wr.en, n == lat);
      chk_bit(o_flag_upd, ar && n == lat);
      if (rd && n == 1) chk_word(32'({o_rd.bank, o_rd.src_addr, o_rd.dst_addr}),
                                 32'({bank, src, dst}));
      if (n == lat) begin
        chk_word(o_wr.data, ed);
        chk_word(32'({o_wr.bank, o_wr.addr}), 32'({bank ^ (op == 6'h24), dst}));
      end
    end
    chk_word(32'(takes), (op == 6'h26) ? 32'h0000_0002 : 32'h0000_0000);
    chk_flags(o_flags, flags_exp);
    $display("test op %h bank %0d finished", op, bank);
  endtask

  task automatic do_reset();
    i_nrst = 1'b0;
    i_issue = 1'b0;
    repeat (3) @(negedge i_clk);
    chk_bit(o_busy, 1'b0);
    chk_flags(o_flags, 3'b000);
    i_nrst = 1'b1;
    flags_exp = 3'b000;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Corner cases first, then random traffic, then a reset in mid-run
  initial begin
    seed = 72;
    do_reset();
    run(6'h26, 5'h03, 5'h04, 1'b0, 32'h0000_1234, 32'hABCD_0000, 1);
    run(6'h23, 5'h1F, 5'h05, 1'b1, 32'h0, 32'hFFFF_FFFF, 3);
    run(6'h24, 5'h06, 5'h07, 1'b1, 32'h8765_4321, 32'h0, 1);
    run(6'h37, 5'h01, 5'h02, 1'b0, 32'h0000_0000, 32'h5, 1);
    run(6'h37, 5'h01, 5'h02, 1'b0, 32'hBF80_0001, 32'h5, 4);
    run(6'h10, 5'h08, 5'h09, 1'b0, 32'h1234_FFFF, 32'h0001_FFFF, 1);
    run(6'h10, 5'h08, 5'h09, 1'b1, 32'hFFFF_0000, 32'h0000_0007, 1);
    run(6'h08, 5'h0A, 5'h0B, 1'b0, 32'h1, 32'h8000_0000, 1);
    run(6'h08, 5'h0A, 5'h0B, 1'b1, 32'h1, 32'h0000_0000, 1);
    run(6'h08, 5'h0A, 5'h0B, 1'b0, 32'h1, 32'hFFFF_FFFF, 1);
    run(6'h38, 5'h0C, 5'h0D, 1'b0, 32'h0000_0000, 32'h1, 1);
    run(6'h38, 5'h0C, 5'h0D, 1'b0, 32'h0000_000F, 32'h1, 1);
    run(6'h38, 5'h0C, 5'h0D, 1'b1, 32'h0000_0010, 32'h1, 1);
    run(6'h38, 5'h0C, 5'h0D, 1'b0, 32'hFFFF_FFFF, 32'h1, 1);
    run(6'h01, 5'h0C, 5'h0D, 1'b0, 32'h1, 32'h1, 1);
    for (k = 0; k < 60; k++) begin
      run(ops[$unsigned($random(seed)) % 7], 5'($random(seed)), 5'($random(seed)),
          1'($random(seed)), $random(seed), $random(seed), 1);
    end
    do_reset();
    run(6'h10, 5'h02, 5'h03, 1'b1, 32'h0000_0000, 32'h0000_FFFF, 1);
    stop_test();
  end
endmodule // rme_exec_tb
`default_nettype wire
